// File: brownout_reset_control.sv
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps

// ****************************************************************
// Shared constants and types
// ****************************************************************
package brownout_pkg;

  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;

  // Control register field positions
  localparam int unsigned SBEN_BIT = 6;
  localparam int unsigned PORF_BIT = 1;
  localparam int unsigned BORF_BIT = 0;

  // Control register reset values
  localparam logic SBEN_RESET = 1'b1;
  localparam logic PORF_RESET = 1'b0;
  localparam logic BORF_RESET = 1'b0;

  // Status register field positions
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_DET_BIT   = 2;
  localparam int unsigned ST_RST_BIT   = 3;
  localparam int unsigned ST_LOW_BIT   = 4;
  localparam int unsigned ST_TMR_BIT   = 5;
  localparam int unsigned ST_LVL_LSB   = 8;
  localparam int unsigned ST_CFG_LSB   = 10;

  // Timing: figures in their own unit, cycles derived from them
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned BROWNOUT_MIN_NS   = 200;
  localparam int unsigned POWERUP_DELAY_US  = 1000;
  localparam int unsigned BROWNOUT_MIN_CYC  =
    (BROWNOUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POWERUP_DELAY_CYC =
    (POWERUP_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Enable configuration field encodings
  typedef enum logic [1:0] {
    CFG_OFF     = 2'b00,
    CFG_SOFT    = 2'b01,
    CFG_NOSLEEP = 2'b10,
    CFG_ON      = 2'b11
  } brownout_cfg_t;

  // Reset sequencer states
  typedef enum logic [1:0] {
    ST_RUN      = 2'b00,
    ST_BROWNOUT = 2'b01,
    ST_DELAY    = 2'b10
  } seq_state_t;

endpackage

// What this block does
// - With detection enabled, a low supply longer than the minimum duration resets the chip.
// - Brown-out reset holds for as long as the supply stays low.
// - With the delay timer enabled, recovery starts it and reset lasts the full delay.
// - Supply low again during the delay re-enters brown-out reset and restarts the delay.
// - Brown-out detection and the delay timer are enabled independently.
// - In setting 01 the software enable bit turns detection on and off.
// - Outside setting 01 the software enable bit has no effect and reads 0.
// - The threshold comes only from the level field and software cannot change it.
// - With detection enabled, every brown-out entry from run and every power-on reset clears the brown-out flag.
// - In setting 10 detection runs in run and idle and is off during sleep.
// - In setting 11 detection is always on.
// - In setting 00 detection is always off and software cannot turn it on.
module brownout_reset_control
  import brownout_pkg::*;
#(
  parameter int unsigned POWERUP_DELAY_CYCLES = POWERUP_DELAY_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        supply_low,
  input  wire logic [1:0]  brownout_enable_cfg,
  input  wire logic [1:0]  brownout_level_sel,
  input  wire logic        powerup_timer_en,
  input  wire logic        sleep_mode,
  output logic             chip_reset,
  output logic             comparator_enable,
  output logic [1:0]       threshold_sel
);

  // ****************************************************************
  // Input synchronisers and configuration capture
  // ****************************************************************
  logic       low_meta_reg;
  logic       low_sync_reg;
  logic [1:0] cfg_meta_reg;
  logic [1:0] cfg_reg;
  logic [1:0] lvl_meta_reg;
  logic [1:0] lvl_reg;
  logic       tmr_meta_reg;
  logic       tmr_en_reg;
  logic       sleep_meta_reg;
  logic       sleep_reg;

  // Two stages each; only the second stage is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_meta_reg   <= 1'b0;
      low_sync_reg   <= 1'b0;
      cfg_meta_reg   <= 2'b00;
      cfg_reg        <= 2'b00;
      lvl_meta_reg   <= 2'b00;
      lvl_reg        <= 2'b00;
      tmr_meta_reg   <= 1'b0;
      tmr_en_reg     <= 1'b0;
      sleep_meta_reg <= 1'b0;
      sleep_reg      <= 1'b0;
    end else begin
      low_meta_reg   <= supply_low;
      low_sync_reg   <= low_meta_reg;
      cfg_meta_reg   <= brownout_enable_cfg;
      cfg_reg        <= cfg_meta_reg;
      lvl_meta_reg   <= brownout_level_sel;
      lvl_reg        <= lvl_meta_reg;
      tmr_meta_reg   <= powerup_timer_en;
      tmr_en_reg     <= tmr_meta_reg;
      sleep_meta_reg <= sleep_mode;
      sleep_reg      <= sleep_meta_reg;
    end
  end

  // ****************************************************************
  // Detection enable and sequencer
  // ****************************************************************
  seq_state_t state_reg;
  seq_state_t state_next;
  logic       sben_reg;
  logic       detect_next;
  logic       detect_reg;
  logic       qual_done;
  logic       delay_done;
  logic       enter_brownout;

  // Enable per configuration; sben only counts in soft mode
  always_comb begin
    case (brownout_cfg_t'(cfg_reg))
      CFG_OFF:     detect_next = 1'b0;
      CFG_SOFT:    detect_next = sben_reg;
      CFG_NOSLEEP: detect_next = !sleep_reg;
      default:     detect_next = 1'b1;
    endcase
  end

  // Qualifier: low must persist past the minimum duration
  duration_counter #(
    .LIMIT (BROWNOUT_MIN_CYC)
  ) u_low_qual (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (detect_reg && low_sync_reg && state_reg == ST_RUN),
    .done    (qual_done)
  );

  // Power-up delay runs only while the supply stays good
  duration_counter #(
    .LIMIT (POWERUP_DELAY_CYCLES)
  ) u_delay (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (state_reg == ST_DELAY && !low_sync_reg),
    .done    (delay_done)
  );

  assign enter_brownout = (state_reg == ST_RUN) && qual_done;

  // Next state: brown-out entry, hold, optional delay
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (enter_brownout) begin
          state_next = ST_BROWNOUT;
        end
      end
      ST_BROWNOUT: begin
        if (low_sync_reg) begin
          state_next = ST_BROWNOUT;
        end else if (tmr_en_reg) begin
          state_next = ST_DELAY;
        end else begin
          state_next = ST_RUN;
        end
      end
      ST_DELAY: begin
        if (low_sync_reg) begin
          state_next = ST_BROWNOUT;
        end else if (delay_done) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_RUN;
    endcase
  end

  // Sequencer and output registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg         <= ST_RUN;
      detect_reg        <= 1'b0;
      chip_reset        <= 1'b0;
      comparator_enable <= 1'b0;
      threshold_sel     <= 2'b00;
    end else begin
      state_reg         <= state_next;
      detect_reg        <= detect_next;
      chip_reset        <= (state_next != ST_RUN);
      comparator_enable <= detect_next;
      threshold_sel     <= lvl_reg;
    end
  end

  // ****************************************************************
  // APB slave and control register
  // ****************************************************************
  logic        porf_reg;
  logic        borf_reg;
  logic        sben_next;
  logic        porf_next;
  logic        borf_next;
  logic        wr_ctrl;
  logic        setup;
  logic        hit_ctrl;
  logic        hit_status;
  logic [31:0] rdata_next;
  logic [31:0] ctrl_view;
  logic [31:0] status_view;

  assign setup      = psel && !penable;
  assign hit_ctrl   = (paddr == ADDR_CTRL);
  assign hit_status = (paddr == ADDR_STATUS);
  assign wr_ctrl    = psel && penable && pready && pwrite && hit_ctrl
                      && pstrb[0];

  // Control view; sben is masked outside soft mode
  always_comb begin
    ctrl_view           = '0;
    ctrl_view[SBEN_BIT] = (cfg_reg == CFG_SOFT) && sben_reg;
    ctrl_view[PORF_BIT] = porf_reg;
    ctrl_view[BORF_BIT] = borf_reg;
  end

  // Status view: sequencer, enable and synced inputs
  always_comb begin
    status_view                         = '0;
    status_view[ST_STATE_LSB +: 2]      = state_reg;
    status_view[ST_DET_BIT]             = detect_reg;
    status_view[ST_RST_BIT]             = chip_reset;
    status_view[ST_LOW_BIT]             = low_sync_reg;
    status_view[ST_TMR_BIT]             = tmr_en_reg;
    status_view[ST_LVL_LSB +: 2]        = lvl_reg;
    status_view[ST_CFG_LSB +: 2]        = cfg_reg;
  end

  // Read data decode; unmapped addresses read zero with error
  always_comb begin
    if (hit_ctrl) begin
      rdata_next = ctrl_view;
    end else if (hit_status) begin
      rdata_next = status_view;
    end else begin
      rdata_next = '0;
    end
  end

  // Flag updates; a brown-out entry beats a write in same cycle
  always_comb begin
    sben_next = sben_reg;
    porf_next = porf_reg;
    borf_next = borf_reg;
    if (wr_ctrl) begin
      if (cfg_reg == CFG_SOFT) begin
        sben_next = pwdata[SBEN_BIT];
      end
      porf_next = pwdata[PORF_BIT];
      borf_next = pwdata[BORF_BIT];
    end
    if (enter_brownout && detect_reg) begin
      borf_next = 1'b0;
    end
  end

  // Flags reset on power-on; reply registered at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sben_reg <= SBEN_RESET;
      porf_reg <= PORF_RESET;
      borf_reg <= BORF_RESET;
      prdata   <= '0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end else begin
      sben_reg <= sben_next;
      porf_reg <= porf_next;
      borf_reg <= borf_next;
      pready   <= setup;
      if (setup) begin
        prdata  <= pwrite ? 32'h0000_0000 : rdata_next;
        pslverr <= !(hit_ctrl || hit_status);
      end else begin
        prdata  <= '0;
        pslverr <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_brownout_entry;
    state_reg == ST_RUN && qual_done;
  endsequence

  sequence s_in_reset;
    state_reg == ST_BROWNOUT && chip_reset;
  endsequence

  sequence s_recover_timed;
    state_reg == ST_BROWNOUT && !low_sync_reg && tmr_en_reg;
  endsequence

  AST_QUAL_RESET: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_brownout_entry |=> s_in_reset)
    else $error("qualified low did not enter reset");

  AST_NO_EARLY: assert property (
    @(posedge pclk) disable iff (!presetn)
    state_reg == ST_RUN && !low_sync_reg |=> state_reg == ST_RUN)
    else $error("reset entered without low supply");

  AST_HOLD: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_in_reset and low_sync_reg |=> s_in_reset)
    else $error("brown-out reset released while low");

  AST_DELAY_START: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_recover_timed |=> state_reg == ST_DELAY && chip_reset)
    else $error("delay timer not started on recovery");

  AST_RESTART: assert property (
    @(posedge pclk) disable iff (!presetn)
    state_reg == ST_DELAY && low_sync_reg |=> s_in_reset)
    else $error("low during delay did not re-enter reset");

  AST_INDEP: assert property (
    @(posedge pclk) disable iff (!presetn)
    state_reg == ST_BROWNOUT && !low_sync_reg && !tmr_en_reg
    |=> state_reg == ST_RUN && !chip_reset)
    else $error("delay ran although timer disabled");

  AST_SOFT: assert property (
    @(posedge pclk) disable iff (!presetn)
    cfg_reg == CFG_SOFT && $stable(cfg_reg)
    |=> comparator_enable == $past(sben_reg))
    else $error("soft mode enable does not follow bit");

  AST_SBEN_READ: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && hit_ctrl && cfg_reg != CFG_SOFT
    |=> !prdata[SBEN_BIT])
    else $error("soft enable read non-zero outside soft mode");

  AST_LEVEL: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 threshold_sel == $past(lvl_reg))
    else $error("threshold not taken from level field");

  AST_FLAG_CLR: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_brownout_entry and detect_reg |=> !borf_reg)
    else $error("brown-out flag not cleared on reset");

  AST_SLEEP: assert property (
    @(posedge pclk) disable iff (!presetn)
    cfg_reg == CFG_NOSLEEP |=> comparator_enable == !$past(sleep_reg))
    else $error("sleep gating wrong in setting 10");

  AST_ALWAYS_ON: assert property (
    @(posedge pclk) disable iff (!presetn)
    cfg_reg == CFG_ON |=> comparator_enable)
    else $error("detection off in setting 11");

  AST_ALWAYS_OFF: assert property (
    @(posedge pclk) disable iff (!presetn)
    cfg_reg == CFG_OFF |=> !comparator_enable ##0 !detect_reg)
    else $error("detection on in setting 00");

endmodule

// File: duration_counter.sv
`timescale 1ns/1ps

// ****************************************************************
// Saturating duration counter
// ****************************************************************
// Counts while run is high, clears as soon as run drops, and
// raises done once run has lasted LIMIT clock edges. Used for
// both the low-supply qualifier and the power-up delay timer.
module duration_counter #(
  parameter int unsigned LIMIT = 20
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  output logic      done
);

  localparam int unsigned W   = $clog2(LIMIT + 1);
  localparam logic [W-1:0] TOP = W'(LIMIT);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // Saturate at the limit so done stays up while run holds
  always_comb begin
    if (!run) begin
      cnt_next = '0;                  // Any gap restarts the count
    end else if (cnt_reg == TOP) begin
      cnt_next = cnt_reg;
    end else begin
      cnt_next = cnt_reg + W'(1);
    end
  end

  // Count register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Gated with run so a drop is seen in the same cycle
  assign done = run && (cnt_reg == TOP);

  // Dropping run always restarts from zero
  AST_CNT_RESTART: assert property (
    @(posedge pclk) disable iff (!presetn)
    !run |=> (cnt_reg == '0) && !done)
    else $error("counter not cleared after run dropped");

endmodule

// File: brownout_partner.sv
`timescale 1ns/1ps

// ****************************************************************
// Supply comparator and configuration fuse model
// ****************************************************************
module brownout_partner (
  input  wire logic       pclk,
  input  wire logic       low_cmd,
  input  wire logic [1:0] cfg_cmd,
  input  wire logic [1:0] lvl_cmd,
  input  wire logic       tmr_cmd,
  input  wire logic       sleep_cmd,
  output logic            supply_low,
  output logic [1:0]      brownout_enable_cfg,
  output logic [1:0]      brownout_level_sel,
  output logic            powerup_timer_en,
  output logic            sleep_mode
);
  // Analog side settles one edge late, so inputs never move on the edge
  always_ff @(posedge pclk) begin
    supply_low          <= low_cmd;
    brownout_enable_cfg <= cfg_cmd;
    brownout_level_sel  <= lvl_cmd;
    powerup_timer_en    <= tmr_cmd;
    sleep_mode          <= sleep_cmd;
  end
endmodule

// File: brownout_reset_control_test.sv
`timescale 1ns/1ps

// ****************************************************************
// Brown-out reset control bench
// ****************************************************************
module brownout_reset_control_test;
  import brownout_pkg::*;
  localparam int P = 10;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic        pready, pslverr, e;
  logic        low_cmd = 1'b0, tmr_cmd = 1'b0, sleep_cmd = 1'b0;
  logic [1:0]  cfg_cmd = 2'b01, lvl_cmd = 2'b00;
  logic        supply_low, powerup_timer_en, sleep_mode;
  logic [1:0]  brownout_enable_cfg, brownout_level_sel, threshold_sel;
  logic        chip_reset, comparator_enable;
  int          mismatches = 0, checked = 0, m_sben = 1, n, det, seen;
  logic [3:0]  cases [6] = '{4'h2, 4'h4, 4'h6, 4'h8, 4'h9, 4'hD};

  always #5 pclk = ~pclk;

  // Latch any reset pulse between checks
  always @(posedge pclk) if (chip_reset === 1'b1) seen = 1;

  brownout_reset_control #(
    .POWERUP_DELAY_CYCLES(P)
  ) i_brownout_reset_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_low(supply_low), .brownout_enable_cfg(brownout_enable_cfg),
    .brownout_level_sel(brownout_level_sel),
    .powerup_timer_en(powerup_timer_en), .sleep_mode(sleep_mode),
    .chip_reset(chip_reset), .comparator_enable(comparator_enable),
    .threshold_sel(threshold_sel));

  brownout_partner i_brownout_partner (
    .pclk(pclk), .low_cmd(low_cmd), .cfg_cmd(cfg_cmd), .lvl_cmd(lvl_cmd),
    .tmr_cmd(tmr_cmd), .sleep_cmd(sleep_cmd), .supply_low(supply_low),
    .brownout_enable_cfg(brownout_enable_cfg),
    .brownout_level_sel(brownout_level_sel),
    .powerup_timer_en(powerup_timer_en), .sleep_mode(sleep_mode));

  // One APB transfer; the request holds until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    if (k >= 20) mismatches++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    checked++;
    if (g !== x) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask

  // Supply low for len edges, then good again
  task automatic dip(input int len);
    low_cmd <= 1'b1;
    repeat (len) @(posedge pclk);
    low_cmd <= 1'b0;
  endtask

  // Count edges after a dip until reset drops (bounded)
  task automatic recover(output int k);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (chip_reset !== 1'b0 && k < 60);
  endtask

  task automatic results;
    $display("Checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Cut a hang short, far beyond the expected run length
  initial begin
    #500000;
    mismatches++;
    results();
  end

  initial begin
    void'($urandom(32'hD9AEB919));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl_reset", 32'h0000_0040, q);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, q);
    $display("test registers done");
    // Every enable setting, soft bit both ways, sleep both ways
    foreach (cases[i]) begin
      cfg_cmd <= cases[i][3:2];
      sleep_cmd <= cases[i][0];
      lvl_cmd <= 2'($urandom);
      repeat (6) @(posedge pclk);
      apb(1'b1, ADDR_CTRL, {25'h0, cases[i][1], 6'h03});
      if (cases[i][3:2] == 2'b01) m_sben = cases[i][1];
      det = (cases[i][3:2] == 3) || (cases[i][3:2] == 2 && !cases[i][0])
            || (cases[i][3:2] == 1 && m_sben == 1);
      apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("status_cfg_lvl", {cases[i][3:2], lvl_cmd}, q[11:8]);
      apb(1'b0, ADDR_CTRL, 32'h0);
      n = (cases[i][3:2] == 1) && m_sben;
      chk("ctrl_soft", n, q[SBEN_BIT]);
      chk("comparator_enable", det, comparator_enable);
      chk("threshold_sel", lvl_cmd, threshold_sel);
      seen = 0;
      dip($urandom_range(17, 1));
      repeat (6) @(posedge pclk);
      chk("glitch_reset", 0, seen);
      low_cmd <= 1'b1;
      repeat (40) @(posedge pclk);
      chk("brownout_hold", det, chip_reset);
      low_cmd <= 1'b0;
      repeat (6) @(posedge pclk);
      chk("no_timer_release", 0, chip_reset);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("flags", {1'b1, !det}, q[1:0]);
      $display("test setting %0d done", i);
    end
    // Power-on reset in mid-run clears both flags
    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    m_sben = SBEN_RESET;
    repeat (6) @(posedge pclk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("por_flags", 32'h0, q);
    $display("test power-on reset done");
    // Delay timer: full delay, then restart on a dip inside it
    // Release to drop: 1 partner + 2 sync + 1 state + P + 1 out + 1 look
    cfg_cmd <= 2'b11;
    tmr_cmd <= 1'b1;
    repeat (6) @(posedge pclk);
    dip(40);
    recover(n);
    chk("delay_len", P + 6, n);
    dip(40);
    repeat (8) @(posedge pclk);
    chk("delay_active", 1, chip_reset);
    dip(40);
    chk("re_entry", 1, chip_reset);
    recover(n);
    chk("delay_restart", P + 6, n);
    $display("test delay timer done");
    results();
  end

endmodule
